// ===== logic/cbp_pkg.sv
package cbp_pkg;

  // ==========================================================================
  // register offsets
  // ==========================================================================
  localparam int unsigned ADDR_W          = 16;
  localparam logic [15:0] OFS_GAP         = 16'h14d2;
  localparam logic [15:0] OFS_REQ         = 16'h14d3;
  localparam logic [15:0] OFS_ENABLES     = 16'h14d4;
  localparam logic [15:0] OFS_COUNT       = 16'h14d5;
  localparam logic [15:0] OFS_RETIME      = 16'h14d6;
  localparam logic [15:0] OFS_DRV_A       = 16'h14d7;
  localparam logic [15:0] OFS_TRIG_CTL    = 16'h14e0;
  localparam logic [15:0] OFS_STATUS      = 16'h14e1;

  // ==========================================================================
  // field positions and values after reset
  // ==========================================================================
  localparam int unsigned REQ_MODE_BIT    = 7;
  localparam int unsigned RETIME_BIT      = 0;
  localparam int unsigned BYPASS_BIT      = 5;
  localparam int unsigned MODE_LSB        = 3;
  localparam int unsigned TRIG_REG_BIT    = 0;
  localparam int unsigned TRIG_PIN_BIT    = 1;
  localparam int unsigned STAT_MUTED_BIT  = 0;
  localparam int unsigned STAT_ACT_LSB    = 1;
  localparam logic [7:0]  RST_BYTE        = 8'h00;
  localparam logic [5:0]  RST_COUNT       = 6'h00;
  localparam int unsigned MIN_DIV_RATIO   = 8;

  // ==========================================================================
  // driver modes
  // ==========================================================================
  localparam logic [1:0]  DRV_DIFF        = 2'h0;
  localparam logic [1:0]  DRV_SE_PRI      = 2'h1;
  localparam logic [1:0]  DRV_SE_SEP      = 2'h2;

  // ==========================================================================
  // pattern generator
  // ==========================================================================
  localparam int unsigned PSEUDORANDOM_PATTERN_W          = 7;
  localparam int unsigned PSEUDORANDOM_PATTERN_TAP        = 5;
  localparam logic [6:0]  PSEUDORANDOM_PATTERN_SEED       = 7'h7f;

  typedef enum logic [1:0] {ST_IDLE, ST_BURST, ST_GAP} cbp_burst_state_type;

  typedef struct packed {
    logic       req_level;
    logic [5:0] len;
    logic [7:0] gap;
  } cbp_burst_cfg_type;

  typedef struct packed {
    cbp_burst_state_type st;
    logic [5:0]          cnt;
    logic [7:0]          gap_cnt;
    logic                pend;
    logic                trig_prev;
    logic                lvl_prev;
    logic [PSEUDORANDOM_PATTERN_W-1:0]   lfsr;
    logic                out;
  } cbp_gate_state_type;

  typedef struct packed {
    logic [7:0] enables;
    logic       retime;
    logic [2:0] drv_low;
    logic       bypass;
    logic [1:0] mode;
    logic [7:0] gap;
    logic       req_level;
    logic [5:0] count;
    logic [1:0] trig_ctl;
    logic       pin_meta;
    logic       pin_sync;
    logic [7:0] rdata;
    logic       muted;
    logic       out_p;
    logic       out_n;
  } cbp_top_state_type;

endpackage

// ===== logic/cbp_gate.sv
`timescale 1ns/1ps
module cbp_gate (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       lvl_i,
  input  wire logic                       trig_i,
  input  wire logic                       burst_en_i,
  input  wire logic                       pseudorandom_pattern_en_i,
  input  wire cbp_pkg::cbp_burst_cfg_type cfg_i,
  output logic                            out_o,
  output logic                            active_o
);
  import cbp_pkg::*;

  cbp_gate_state_type s_reg;
  cbp_gate_state_type s_next;
  logic               rise;
  logic               trig_rise;
  logic               base;

  // ==========================================================================
  // burst sequencer and pattern generator
  // ==========================================================================
  always_comb begin
    s_next = s_reg;
    rise = lvl_i & ~s_reg.lvl_prev;
    trig_rise = trig_i & ~s_reg.trig_prev;
    s_next.lvl_prev = lvl_i;
    s_next.trig_prev = trig_i;
    if (rise) begin
      s_next.lfsr = {s_reg.lfsr[PSEUDORANDOM_PATTERN_W-2:0], s_reg.lfsr[PSEUDORANDOM_PATTERN_W-1] ^ s_reg.lfsr[PSEUDORANDOM_PATTERN_TAP]};
    end
    if (!burst_en_i) begin
      s_next.st = ST_IDLE;
      s_next.pend = 1'b0;
      s_next.cnt = 6'h00;
    end else begin
      if (trig_rise && !cfg_i.req_level) begin
        s_next.pend = 1'b1;
      end
      case (s_reg.st)
        ST_IDLE: begin
          // a burst starts on a divider rising edge so its first pulse is whole
          if (rise && cfg_i.len != 6'h00 &&
              (cfg_i.req_level ? trig_i : (s_reg.pend | trig_rise))) begin
            s_next.st = ST_BURST;
            s_next.cnt = 6'h01;
            s_next.pend = 1'b0;
          end
        end
        ST_BURST: begin
          if (rise) begin
            if (s_reg.cnt == cfg_i.len) begin
              if (!cfg_i.req_level) begin
                s_next.st = ST_IDLE;
              end else if (cfg_i.gap == 8'h00) begin
                s_next.st = trig_i ? ST_BURST : ST_IDLE;
                s_next.cnt = 6'h01;
              end else begin
                s_next.st = ST_GAP;
                s_next.gap_cnt = 8'h01;
              end
            end else begin
              s_next.cnt = s_reg.cnt + 6'h01;
            end
          end
        end
        ST_GAP: begin
          if (rise) begin
            if (s_reg.gap_cnt == cfg_i.gap) begin
              s_next.st = (trig_i && cfg_i.req_level) ? ST_BURST : ST_IDLE;
              s_next.cnt = 6'h01;
            end else begin
              s_next.gap_cnt = s_reg.gap_cnt + 8'h01;
            end
          end
        end
        default: begin
          s_next.st = ST_IDLE;
        end
      endcase
    end
    base = pseudorandom_pattern_en_i ? s_next.lfsr[PSEUDORANDOM_PATTERN_W-1] : lvl_i;
    s_next.out = burst_en_i ? (base & (s_next.st == ST_BURST)) : base;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '{st: ST_IDLE, lfsr: PSEUDORANDOM_PATTERN_SEED, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign out_o = s_reg.out;
  assign active_o = (s_reg.st == ST_BURST);

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_pseudorandom_pattern_shift: assert property (pseudorandom_pattern_en_i && rise |=>
    s_reg.lfsr[PSEUDORANDOM_PATTERN_W-1:1] == $past(s_reg.lfsr[PSEUDORANDOM_PATTERN_W-2:0]))
    else $error("pattern did not advance on divider edge");
  chk_burst_mute: assert property ($past(burst_en_i) && !active_o |-> !out_o)
    else $error("output not muted outside burst");
  chk_edge_start: assert property (burst_en_i && !cfg_i.req_level && s_reg.st == ST_IDLE
    && s_reg.pend && rise && cfg_i.len != 6'h00 |=> s_reg.st == ST_BURST && s_reg.cnt == 6'h01)
    else $error("pending edge did not start a burst");
  chk_level_stop: assert property (burst_en_i && cfg_i.req_level && s_reg.st == ST_GAP
    && rise && s_reg.gap_cnt == cfg_i.gap && !trig_i |=> s_reg.st == ST_IDLE)
    else $error("level trigger low but bursts continue");
  chk_gap_count: assert property (burst_en_i && s_reg.st == ST_GAP && rise
    && s_reg.gap_cnt != cfg_i.gap |=> s_reg.st == ST_GAP && s_reg.gap_cnt == $past(s_reg.gap_cnt) + 8'h01)
    else $error("gap counter misstep");
  chk_burst_count: assert property (burst_en_i && s_reg.st == ST_BURST && rise
    && s_reg.cnt != cfg_i.len |=> s_reg.st == ST_BURST && s_reg.cnt == $past(s_reg.cnt) + 6'h01)
    else $error("burst ended early or miscounted");

endmodule // cbp_gate

// ===== logic/cbp_ctrl.sv
`timescale 1ns/1ps
module cbp_ctrl #(
  parameter int unsigned NUM_DIV = 4
) (
  input  wire logic                        CLK_SYS_I,
  input  wire logic                        SYS_RST_I,
  input  wire logic [cbp_pkg::ADDR_W-1:0]  REG_ADDR_I,
  input  wire logic [7:0]                  REG_WDATA_I,
  input  wire logic                        REG_WR_I,
  input  wire logic                        REG_RD_I,
  output logic      [7:0]                  REG_RDATA_O,
  input  wire logic                        BURST_TRIG_PIN_I,
  input  wire logic                        RETIME_TRIG_I,
  input  wire logic                        MUTE_A_I,
  input  wire logic [NUM_DIV-1:0]          DIV_LVL_I,
  output logic      [NUM_DIV-1:0]          DIV_OUT_O,
  output logic                             OUT_A_P_O,
  output logic                             OUT_A_N_O
);
  import cbp_pkg::*;

  // ==========================================================================
  // elaboration check
  // ==========================================================================
  // the enable register has room for four dividers, driver a needs two
  generate
    if (NUM_DIV < 2 || NUM_DIV > 4) begin : g_bad_num_div
      $error("NUM_DIV must lie between 2 and 4");
    end
  endgenerate

  cbp_top_state_type s_reg;
  cbp_top_state_type s_next;
  cbp_burst_cfg_type burst_cfg;
  logic              trig_sel;
  logic [NUM_DIV-1:0] active;
  logic [7:0]        rd_val;
  logic [7:0]        status;
  logic              wr_hit_drv;
  logic              safe_to_switch;
  logic              p_src;
  logic              n_src;

  // ==========================================================================
  // trigger source selection
  // ==========================================================================
  // the pin path only ever reads the second synchroniser stage
  always_comb begin
    if (s_reg.retime) begin
      trig_sel = RETIME_TRIG_I;
    end else if (s_reg.trig_ctl[TRIG_PIN_BIT]) begin
      trig_sel = s_reg.pin_sync;
    end else begin
      trig_sel = s_reg.trig_ctl[TRIG_REG_BIT];
    end
  end

  always_comb begin
    burst_cfg.req_level = s_reg.req_level;
    burst_cfg.len = s_reg.count;
    burst_cfg.gap = s_reg.gap;
  end

  // ==========================================================================
  // per-divider burst and pattern gates
  // ==========================================================================
  // the divide ratio of at least eight is left to software; the gate
  // only relies on seeing a distinct low phase between rising edges
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DIV; gi++) begin : g_div
      cbp_gate u_gate (
        .clk_i      (CLK_SYS_I),
        .rst_i      (SYS_RST_I),
        .lvl_i      (DIV_LVL_I[gi]),
        .trig_i     (trig_sel),
        .burst_en_i (s_reg.enables[2*gi]),
        .pseudorandom_pattern_en_i  (s_reg.enables[2*gi+1]),
        .cfg_i      (burst_cfg),
        .out_o      (DIV_OUT_O[gi]),
        .active_o   (active[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // status and read mux
  // ==========================================================================
  always_comb begin
    status = 8'h00;
    status[STAT_MUTED_BIT] = s_reg.muted;
    for (int i = 0; i < NUM_DIV; i++) begin
      status[STAT_ACT_LSB+i] = active[i];
    end
  end

  always_comb begin
    rd_val = 8'h00;
    case (REG_ADDR_I)
      OFS_GAP: begin
        rd_val = s_reg.gap;
      end
      OFS_REQ: begin
        rd_val[REQ_MODE_BIT] = s_reg.req_level;
      end
      OFS_ENABLES: begin
        rd_val = s_reg.enables;
      end
      OFS_COUNT: begin
        rd_val[5:0] = s_reg.count;
      end
      OFS_RETIME: begin
        rd_val[RETIME_BIT] = s_reg.retime;
      end
      OFS_DRV_A: begin
        rd_val[2:0] = s_reg.drv_low;
        rd_val[MODE_LSB+1:MODE_LSB] = s_reg.mode;
        rd_val[BYPASS_BIT] = s_reg.bypass;
      end
      OFS_TRIG_CTL: begin
        rd_val[1:0] = s_reg.trig_ctl;
      end
      OFS_STATUS: begin
        rd_val = status;
      end
      default: begin
        rd_val = 8'h00;
      end
    endcase
  end

  // ==========================================================================
  // driver source and mute
  // ==========================================================================
  // in differential mode the inverted pin is high while the primary is
  // low, so a retimed mute there still shortens one negative-pin pulse
  always_comb begin
    case (s_reg.mode)
      DRV_DIFF: begin
        p_src = DIV_OUT_O[0];
        n_src = ~DIV_OUT_O[0];
      end
      DRV_SE_PRI: begin
        p_src = DIV_OUT_O[0];
        n_src = DIV_OUT_O[0];
      end
      DRV_SE_SEP: begin
        p_src = DIV_OUT_O[0];
        n_src = DIV_OUT_O[1];
      end
      default: begin
        p_src = DIV_OUT_O[0];
        n_src = ~DIV_OUT_O[0];
      end
    endcase
    safe_to_switch = !DIV_OUT_O[0] && !(s_reg.mode == DRV_SE_SEP && DIV_OUT_O[1]);
  end

  assign wr_hit_drv = REG_WR_I && (REG_ADDR_I == OFS_DRV_A);

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    s_next = s_reg;
    s_next.pin_meta = BURST_TRIG_PIN_I;
    s_next.pin_sync = s_reg.pin_meta;
    s_next.rdata = 8'h00;
    if (REG_RD_I) begin
      s_next.rdata = rd_val;
    end
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        OFS_GAP: begin
          s_next.gap = REG_WDATA_I;
        end
        OFS_REQ: begin
          s_next.req_level = REG_WDATA_I[REQ_MODE_BIT];
        end
        OFS_ENABLES: begin
          s_next.enables = REG_WDATA_I;
        end
        OFS_COUNT: begin
          s_next.count = REG_WDATA_I[5:0];
        end
        OFS_RETIME: begin
          s_next.retime = REG_WDATA_I[RETIME_BIT];
        end
        OFS_DRV_A: begin
          s_next.drv_low = REG_WDATA_I[2:0];
          s_next.mode = REG_WDATA_I[MODE_LSB+1:MODE_LSB];
          s_next.bypass = REG_WDATA_I[BYPASS_BIT];
        end
        OFS_TRIG_CTL: begin
          s_next.trig_ctl = REG_WDATA_I[1:0];
        end
        default: begin
          s_next.trig_ctl = s_reg.trig_ctl;
        end
      endcase
    end
    if (s_reg.bypass) begin
      s_next.muted = MUTE_A_I;
    end else if (safe_to_switch) begin
      s_next.muted = MUTE_A_I;
    end
    s_next.out_p = p_src & ~s_next.muted;
    s_next.out_n = n_src & ~s_next.muted;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      s_reg <= '{enables: RST_BYTE, gap: RST_BYTE, count: RST_COUNT, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign REG_RDATA_O = s_reg.rdata;
  assign OUT_A_P_O = s_reg.out_p;
  assign OUT_A_N_O = s_reg.out_n;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);

  chk_count_write: assert property (REG_WR_I && REG_ADDR_I == OFS_COUNT |=>
    s_reg.count == $past(REG_WDATA_I[5:0]))
    else $error("burst length field not written");
  chk_count_read: assert property (REG_RD_I && REG_ADDR_I == OFS_COUNT |=>
    REG_RDATA_O == {2'h0, $past(s_reg.count)} ##1 REG_RDATA_O == 8'h00 || $past(REG_RD_I))
    else $error("burst length readback wrong");
  chk_gap_read: assert property (REG_RD_I && REG_ADDR_I == OFS_GAP |=>
    REG_RDATA_O == $past(s_reg.gap))
    else $error("gap readback wrong");
  chk_trig_internal: assert property (s_reg.retime |-> trig_sel == RETIME_TRIG_I)
    else $error("internal retiming source not selected");
  chk_trig_user: assert property (!s_reg.retime && !s_reg.trig_ctl[TRIG_PIN_BIT] |->
    trig_sel == s_reg.trig_ctl[TRIG_REG_BIT])
    else $error("register trigger source not selected");
  chk_mute_retime: assert property (!$past(s_reg.bypass) && s_reg.muted != $past(s_reg.muted)
    |-> !$past(DIV_OUT_O[0]))
    else $error("mute switched while primary high");
  chk_mute_bypass: assert property (s_reg.bypass && MUTE_A_I |=>
    !OUT_A_P_O && !OUT_A_N_O && s_reg.muted)
    else $error("bypassed mute not immediate");
  chk_diff_mode: assert property (s_reg.mode == DRV_DIFF && !wr_hit_drv && !MUTE_A_I
    && !s_reg.muted |=> OUT_A_N_O != OUT_A_P_O && OUT_A_P_O == $past(DIV_OUT_O[0]))
    else $error("differential pins not complementary");
  chk_se_primary: assert property (s_reg.mode == DRV_SE_PRI && !wr_hit_drv && !MUTE_A_I
    && !s_reg.muted |=> OUT_A_N_O == OUT_A_P_O && OUT_A_P_O == $past(DIV_OUT_O[0]))
    else $error("single-ended pins not both from primary");
  chk_se_separate: assert property (s_reg.mode == DRV_SE_SEP && !wr_hit_drv && !MUTE_A_I
    && !s_reg.muted |=> OUT_A_P_O == $past(DIV_OUT_O[0]) && OUT_A_N_O == $past(DIV_OUT_O[1]))
    else $error("separate dividers not routed to pins");

endmodule // cbp_ctrl

// ===== sim/cbp_clk_sink.sv
`timescale 1ns/1ps
// ============================================================================
// clock receiver: counts rising edges seen on one incoming clock line
// ============================================================================
module cbp_clk_sink (
  input  wire logic       clk_i,
  input  wire logic       clr_i,
  input  wire logic       line_i,
  output logic      [7:0] edges_o
);
  logic prev_reg;

  always_ff @(posedge clk_i) begin
    prev_reg <= line_i;
    if (clr_i) begin
      edges_o <= 8'h00;
    end else if (line_i && !prev_reg) begin
      // a runt or cut pulse would still count, so the count does not tell whole pulses from cut ones
      edges_o <= edges_o + 8'h01;
    end
  end
endmodule // cbp_clk_sink

// ===== sim/cbp_ctrl_tb.sv
`timescale 1ns/1ps
module cbp_ctrl_tb;
  import cbp_pkg::*;
  logic        clk, rst, wr, rd, pin, rtrig, mute, clr, op, on, ok1, ok2, any;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata, edges, rnd, rv, len;
  logic [3:0]  lvl, dout, h1, h2;
  logic [3:0]  ph [4];
  logic        s [24];
  int          mismatches, compares, n;
  localparam logic [15:0] OFFS [8] = '{OFS_GAP, OFS_REQ, OFS_ENABLES, OFS_COUNT,
                                       OFS_RETIME, OFS_DRV_A, OFS_TRIG_CTL, 16'h14d1};
  localparam logic [7:0]  MASK [8] = '{8'hff, 8'h80, 8'hff, 8'h3f, 8'h01, 8'h3f, 8'h03, 8'h00};

  cbp_ctrl #(.NUM_DIV(4)) dut_u (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .BURST_TRIG_PIN_I(pin),
    .RETIME_TRIG_I(rtrig), .MUTE_A_I(mute), .DIV_LVL_I(lvl), .DIV_OUT_O(dout),
    .OUT_A_P_O(op), .OUT_A_N_O(on)
  );
  cbp_clk_sink sink_u (.clk_i(clk), .clr_i(clr), .line_i(dout[0]), .edges_o(edges));

  // ==========================================================================
  // clock and divider models
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // divider 1 runs at a different ratio so the separate-divider mode is visible
  function automatic logic [3:0] per(input int i);
    return (i == 1) ? 4'ha : 4'h8;
  endfunction

  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      ph[i] <= (ph[i] == per(i) - 4'h1) ? 4'h0 : ph[i] + 4'h1;
    end
    h1 <= lvl;
    h2 <= h1;
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lvl[i] = ph[i] < (per(i) >> 1);
    end
  end

  // ==========================================================================
  // tasks
  // ==========================================================================
  function automatic logic [7:0] next(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  task automatic results;
    if (mismatches == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // polls the burst-active status bit of divider 0 with a bound
  task automatic wait_stat(input logic want);
    logic [7:0] st;
    int k;
    k = 0;
    do begin
      rreg(OFS_STATUS, st);
      k++;
    end while (st[STAT_ACT_LSB] !== want && k < 100);
    if (st[STAT_ACT_LSB] !== want) begin
      mismatches++;
      results();
    end
  endtask

  // waits for a given divider 0 phase, with a bound
  task automatic wait_ph(input logic [3:0] v);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ph[0] != v && k < 16);
    if (ph[0] != v) begin
      mismatches++;
      results();
    end
  endtask

  task automatic pulse_clr;
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 16'h0000; wdata = 8'h00;
    pin = 1'b0; rtrig = 1'b0; mute = 1'b0; clr = 1'b1; rnd = 8'h46;
    mismatches = 0; compares = 0;
    for (int i = 0; i < 4; i++) ph[i] = 4'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rreg(OFFS[i], rv);
      chk("reset value", 8'h00, rv);
    end
    for (int r = 0; r < 3; r++) begin
      for (int i = 0; i < 8; i++) begin
        rnd = next(rnd);
        wreg(OFFS[i], rnd);
        rreg(OFFS[i], rv);
        chk("register", rnd & MASK[i], rv);
      end
    end
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wreg(OFS_ENABLES, 8'h01);
    pulse_clr();
    repeat (16) @(posedge clk);
    chk("muted idle", 8'h00, edges);
    // one counted burst from each trigger source
    for (int src = 0; src < 3; src++) begin
      rnd = next(rnd);
      len = 8'h01 + rnd % 8'h06;
      wreg(OFS_COUNT, len);
      pulse_clr();
      case (src)
        0: begin
          wreg(OFS_TRIG_CTL, 8'h01);
          wreg(OFS_TRIG_CTL, 8'h00);
        end
        1: begin
          wreg(OFS_TRIG_CTL, 8'h02);
          pin <= 1'b1;
          repeat (3) @(posedge clk);
          pin <= 1'b0;
        end
        default: begin
          wreg(OFS_RETIME, 8'h01);
          rtrig <= 1'b1;
          @(posedge clk);
          rtrig <= 1'b0;
          wreg(OFS_RETIME, 8'h00);
        end
      endcase
      wait_stat(1'b1);
      wait_stat(1'b0);
      chk("burst pulses", len, edges);
    end
    // level mode keeps bursting while the trigger is high
    rnd = next(rnd);
    wreg(OFS_GAP, rnd & 8'h03);
    wreg(OFS_REQ, 8'h80);
    wreg(OFS_COUNT, 8'h02);
    pulse_clr();
    wreg(OFS_TRIG_CTL, 8'h01);
    n = 0;
    while (edges < 8'h06 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("repeated bursts", 8'h06, edges);
    wreg(OFS_TRIG_CTL, 8'h00);
    wait_stat(1'b0);
    chk("whole bursts", 8'h00, edges % 8'h02);
    wreg(OFS_REQ, 8'h00);
    // pattern output must obey the generator recurrence
    wreg(OFS_ENABLES, 8'h02);
    repeat (16) @(posedge clk);
    for (int k = 0; k < 24; k++) begin
      wait_ph(4'h3);
      #1;
      s[k] = dout[0];
    end
    ok1 = 1'b1; ok2 = 1'b1; any = 1'b0;
    for (int k = 7; k < 24; k++) begin
      ok1 &= (s[k] == (s[k-6] ^ s[k-7]));
      ok2 &= (s[k] == (s[k-1] ^ s[k-7]));
      any |= s[k];
    end
    chk("pattern", 8'h01, 8'((ok1 | ok2) & any));
    // driver modes, mode 3 falls back to differential
    wreg(OFS_ENABLES, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wreg(OFS_DRV_A, 8'(m << MODE_LSB));
      repeat (4) @(posedge clk);
      for (int k = 0; k < 20; k++) begin
        @(posedge clk);
        #1;
        chk("plain divider", 8'(h1), 8'(dout));
        chk("pin p", 8'(h2[0]), 8'(op));
        chk("pin n", {7'h00, (m == 2) ? h2[1] : ((m == 1) ? h2[0] : ~h2[0])}, 8'(on));
      end
    end
    // mute raised in mid-pulse: cut at once only with the bypass set
    for (int b = 0; b < 2; b++) begin
      wreg(OFS_DRV_A, (b == 1) ? 8'h28 : 8'h08);
      repeat (10) @(posedge clk);
      wait_ph(4'h1);
      mute <= 1'b1;
      @(posedge clk);
      #1;
      chk("mute timing", (b == 1) ? 8'h00 : 8'h01, 8'(op));
      repeat (8) @(posedge clk);
      #1;
      chk("muted pins", 8'h00, 8'({op, on}));
      @(posedge clk);
      mute <= 1'b0;
    end
    results();
  end

  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    results();
  end
endmodule // cbp_ctrl_tb
